// ==== src/fts_pkg.sv ====
// Purpose: shared constants and types of the flow-through burst memory port
// Assumes: one clock, synchronous host signals
// Notes:   widths follow the 256K by 18 array with two 9-bit byte lanes
package fts_pkg;
  localparam int FTS_ADDR_W   = 18;
  localparam int FTS_DATA_W   = 18;
  localparam int FTS_LANES    = 2;
  localparam int FTS_LANE_W   = 9;
  localparam int FTS_BURST_W  = 2;
  localparam int FTS_UPPER_LO = FTS_BURST_W;

  localparam logic MODE_LINEAR      = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;

  localparam logic [FTS_BURST_W-1:0] FTS_BEAT_ONE  = 2'h1;
  localparam logic [FTS_BURST_W-1:0] FTS_BEAT_ZERO = 2'h0;

  typedef enum logic [1:0] {
    FTS_OP_IDLE  = 2'b00,
    FTS_OP_READ  = 2'b01,
    FTS_OP_WRITE = 2'b10
  } fts_op_type;

  // host command group sampled on each qualified edge
  typedef struct packed {
    logic [FTS_ADDR_W-1:0] addr;
    logic                  advance_or_load;
    logic                  select_one_n;
    logic                  select_two;
    logic                  select_three_n;
    logic                  write_n;
    logic [FTS_LANES-1:0]  byte_lane_write_n;
  } fts_cmd_type;

  typedef struct packed {
    fts_op_type            op;
    logic [FTS_ADDR_W-1:0] addr;
    logic                  deselected;
    logic                  wr_pend;
    logic [FTS_ADDR_W-1:0] wr_addr;
    logic [FTS_LANES-1:0]  wr_lane;
    logic                  drive;
    logic [FTS_DATA_W-1:0] dout;
  } fts_port_state_type;

  typedef struct packed {
    logic [FTS_BURST_W-1:0] start;
    logic [FTS_BURST_W-1:0] cnt;
  } fts_burst_state_type;

  function automatic logic fts_selected(input fts_cmd_type c);
    fts_selected = ~c.select_one_n & c.select_two & ~c.select_three_n;
  endfunction : fts_selected
endpackage : fts_pkg

// ==== src/fts_burst_counter.sv ====
// Purpose: two-bit burst address sequencer, linear or interleaved
// Assumes: en_i is the qualified clock of the port
// Notes:   wraps inside a four-word group
`timescale 1ns/100ps
module fts_burst_counter (
  input  wire logic                           clk_i,     // port clock
  input  wire logic                           rst_i,     // sync reset, high
  input  wire logic                           en_i,      // qualified edge
  input  wire logic                           load_i,    // take new start
  input  wire logic                           mode_i,    // burst order
  input  wire logic [fts_pkg::FTS_BURST_W-1:0] start_i,  // low address bits
  output logic      [fts_pkg::FTS_BURST_W-1:0] nxt_low_o // low bits for this edge
);
  import fts_pkg::*;

  fts_burst_state_type r_ff;
  fts_burst_state_type nxt_r;
  logic [FTS_BURST_W-1:0] step;

  always_comb begin
    nxt_r = r_ff;
    step  = r_ff.cnt + FTS_BEAT_ONE;
    // counter range equals the group size, so both orders wrap in four words
    if (load_i) begin
      nxt_low_o = start_i;
    end else if (mode_i == MODE_INTERLEAVED) begin
      nxt_low_o = r_ff.start ^ step;
    end else begin
      nxt_low_o = r_ff.start + step;
    end
    if (en_i) begin
      if (load_i) begin
        nxt_r.start = start_i;
        nxt_r.cnt   = FTS_BEAT_ZERO;
      end else begin
        nxt_r.cnt = step;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  property p_hold_without_edge;
    @(posedge clk_i) disable iff (rst_i)
      !en_i |=> r_ff == $past(r_ff);
  endproperty
  a_hold_without_edge: assert property (p_hold_without_edge)
    else $error("burst counter moved without a qualified edge");
endmodule : fts_burst_counter

// ==== src/fts_sram_port.sv ====
// Purpose: synchronous host port of a flow-through burst memory, 256K x 18
// Assumes: host signals synchronous to clk_i; write data one edge after command
// Notes:   read word is latched at the address edge, so it stands in the following cycle
`timescale 1ns/100ps

// Notes on behaviour
// - all synchronous inputs are captured on the rising clock edge
// - clock qualifier high: edge ignored, all state held
// - reads and writes follow back to back with no wait cycles
// - writes decided by write command and two lane strobes, self timed
// - only lanes with low strobe are updated during a write
// - write command low starts a write, sampled only on qualified edges
// - selected only when all three selects active; output enable gates drivers
// - drivers off during the data phase of every write
// - bus direction kept internally even with output enable held low
// - registered address selects one of 256K words of 18 bits
// - two lowest address bits load the two-bit burst counter
// - linear or interleaved order chosen by static mode input
// - inputs registered only, read data with no output pipeline stage
// - bus driven only with output enable low and internal permission
// - advance high steps the counter, low loads a new address
// - select one and three active low, select two active high
// - outputs off while deselected and first cycle after leaving it
// - sleep request halts operation and keeps stored data
module fts_sram_port (
  input  wire logic                          clk_i,             // port clock
  input  wire logic                          rst_i,             // sync reset, high
  input  wire logic                          clock_qualifier_n_i, // low: edge counts
  input  wire fts_pkg::fts_cmd_type          cmd_i,             // address and controls
  input  wire logic                          mode_i,            // burst order, static
  input  wire logic                          output_enable_n_i, // async output enable
  input  wire logic                          sleep_request_i,   // low-power request
  input  wire logic [fts_pkg::FTS_DATA_W-1:0] dq_i,             // data and parity in
  output logic      [fts_pkg::FTS_DATA_W-1:0] dq_o,             // data and parity out
  output logic                               dq_oe_o            // high while driving
);
  import fts_pkg::*;

  localparam int DEPTH = 1 << FTS_ADDR_W;

  generate
    if (FTS_DATA_W != FTS_LANES * FTS_LANE_W) begin : g_bad_width
      $error("data width must be lanes times lane width");
    end
  endgenerate

  logic [FTS_DATA_W-1:0] mem_ff [DEPTH];

  fts_port_state_type    r_ff;
  fts_port_state_type    nxt_r;
  logic                  en;
  logic                  sel;
  logic                  advance;
  logic                  cnt_en;
  logic [FTS_BURST_W-1:0] nxt_low;
  logic [FTS_DATA_W-1:0] wr_word;
  logic [FTS_DATA_W-1:0] rd_word;

  assign en      = ~clock_qualifier_n_i & ~sleep_request_i;
  assign sel     = fts_selected(cmd_i);
  assign advance = cmd_i.advance_or_load & (r_ff.op != FTS_OP_IDLE);
  assign cnt_en  = en & (~cmd_i.advance_or_load | advance);

  fts_burst_counter u_burst (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (cnt_en),
    .load_i    (~cmd_i.advance_or_load),
    .mode_i    (mode_i),
    .start_i   (cmd_i.addr[FTS_BURST_W-1:0]),
    .nxt_low_o (nxt_low)
  );

  // merged word of the write retiring on this edge
  always_comb begin
    wr_word = mem_ff[r_ff.wr_addr];
    for (int l = 0; l < FTS_LANES; l++) begin
      if (r_ff.wr_lane[l]) begin
        wr_word[l*FTS_LANE_W +: FTS_LANE_W] = dq_i[l*FTS_LANE_W +: FTS_LANE_W];
      end
    end
  end

  always_comb begin
    nxt_r   = r_ff;
    rd_word = '0;
    if (sleep_request_i) begin
      // a write whose data edge falls in sleep is dropped
      nxt_r.op         = FTS_OP_IDLE;
      nxt_r.deselected = 1'b1;
      nxt_r.wr_pend    = 1'b0;
      nxt_r.drive      = 1'b0;
    end else if (en) begin
      if (advance) begin
        nxt_r.addr = {r_ff.addr[FTS_ADDR_W-1:FTS_UPPER_LO], nxt_low};
      end else if (!cmd_i.advance_or_load && sel) begin
        nxt_r.op   = cmd_i.write_n ? FTS_OP_READ : FTS_OP_WRITE;
        nxt_r.addr = cmd_i.addr;
      end else if (!cmd_i.advance_or_load) begin
        nxt_r.op = FTS_OP_IDLE;
      end
      nxt_r.deselected = (nxt_r.op == FTS_OP_IDLE);
      nxt_r.wr_pend    = (nxt_r.op == FTS_OP_WRITE);
      nxt_r.wr_addr    = nxt_r.addr;
      nxt_r.wr_lane    = ~cmd_i.byte_lane_write_n;
      // drivers released for write data, deselect and the first cycle out of it
      nxt_r.drive = (nxt_r.op == FTS_OP_READ) && !r_ff.deselected;
      rd_word = mem_ff[nxt_r.addr];
      if (r_ff.wr_pend && r_ff.wr_addr == nxt_r.addr) begin
        rd_word = wr_word; // forward so write-to-read needs no idle cycle
      end
      nxt_r.dout = rd_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff            <= '0;
      r_ff.deselected <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // array has no reset: stored data survives reset and sleep
  always_ff @(posedge clk_i) begin
    if (!rst_i && en && r_ff.wr_pend) begin
      mem_ff[r_ff.wr_addr] <= wr_word;
    end
  end

  assign dq_o = r_ff.dout;
  // the enable pin is asynchronous, so it gates the registered permission directly
  assign dq_oe_o = r_ff.drive & ~output_enable_n_i;

  sequence s_write_cmd;
    en && !cmd_i.advance_or_load && sel && !cmd_i.write_n;
  endsequence

  sequence s_deselect_cmd;
    en && !cmd_i.advance_or_load && !sel;
  endsequence

  property p_write_releases_bus;
    @(posedge clk_i) disable iff (rst_i)
      s_write_cmd |=> !dq_oe_o && r_ff.wr_pend;
  endproperty
  a_write_releases_bus: assert property (p_write_releases_bus)
    else $error("bus driven during write data phase");

  property p_deselect_quiet;
    @(posedge clk_i) disable iff (rst_i)
      s_deselect_cmd |=> !dq_oe_o && r_ff.deselected;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet)
    else $error("bus driven while deselected");

  property p_first_after_deselect;
    @(posedge clk_i) disable iff (rst_i)
      r_ff.deselected && en && !cmd_i.advance_or_load && sel |=> !r_ff.drive;
  endproperty
  a_first_after_deselect: assert property (p_first_after_deselect)
    else $error("bus driven on first cycle after deselect");

  property p_stall_holds;
    @(posedge clk_i) disable iff (rst_i)
      clock_qualifier_n_i && !sleep_request_i |=> r_ff == $past(r_ff);
  endproperty
  a_stall_holds: assert property (p_stall_holds)
    else $error("state changed on a masked edge");

  property p_read_back_to_back;
    @(posedge clk_i) disable iff (rst_i)
      r_ff.op == FTS_OP_READ && !r_ff.deselected && en && !cmd_i.advance_or_load
        && sel && cmd_i.write_n |=> r_ff.drive && r_ff.addr == $past(cmd_i.addr);
  endproperty
  a_read_back_to_back: assert property (p_read_back_to_back)
    else $error("back-to-back read not served");

  // driving needs the enable pin low and a read data phase behind it
  property p_oe_gates;
    @(posedge clk_i) disable iff (rst_i)
      dq_oe_o |-> !output_enable_n_i && r_ff.op == FTS_OP_READ;
  endproperty
  a_oe_gates: assert property (p_oe_gates)
    else $error("bus driven with output enable high");

  property p_read_data;
    @(posedge clk_i) disable iff (rst_i)
      en && !cmd_i.advance_or_load && sel && cmd_i.write_n && !r_ff.wr_pend
        |=> dq_o == mem_ff[r_ff.addr];
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read word differs from stored word");

  property p_burst_group;
    @(posedge clk_i) disable iff (rst_i)
      en && advance |=> r_ff.addr[FTS_ADDR_W-1:FTS_UPPER_LO]
        == $past(r_ff.addr[FTS_ADDR_W-1:FTS_UPPER_LO]);
  endproperty
  a_burst_group: assert property (p_burst_group)
    else $error("burst left its four-word group");

  // judged on the stored word after the write retires, not on the merge logic
  property p_lane_keep;
    @(posedge clk_i) disable iff (rst_i)
      en && r_ff.wr_pend && !r_ff.wr_lane[1]
        |=> mem_ff[$past(r_ff.wr_addr)][FTS_DATA_W-1:FTS_LANE_W]
          == $past(mem_ff[r_ff.wr_addr][FTS_DATA_W-1:FTS_LANE_W]);
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("unstrobed lane was overwritten");

  property p_sleep_off;
    @(posedge clk_i) disable iff (rst_i)
      sleep_request_i |=> !dq_oe_o && !r_ff.wr_pend;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("activity during sleep");
endmodule : fts_sram_port

// ==== bench/fts_host_model.sv ====
// Purpose: far-side model of the shared word lines seen by the port
// Assumes: host drives write data only in the data phase of a write
// Notes:   released lines show the inverse of the last level, never a held word
`timescale 1ns/100ps
module fts_host_model (
  input  wire logic                           clk_i,      // port clock
  input  wire logic [fts_pkg::FTS_DATA_W-1:0] dq_o_i,     // port read word
  input  wire logic                           dq_oe_i,    // port drives
  input  wire logic                           host_drv_i, // host drives write data
  input  wire logic [fts_pkg::FTS_DATA_W-1:0] host_dat_i, // host write word
  output logic      [fts_pkg::FTS_DATA_W-1:0] dq_wire_o,  // resolved bus level
  output logic                                clash_o     // both sides driving
);
  import fts_pkg::*;
  logic [FTS_DATA_W-1:0] last_ff;
  always_ff @(posedge clk_i) begin
    last_ff <= dq_wire_o;
  end
  always_comb begin
    if (dq_oe_i) begin
      dq_wire_o = dq_o_i;
    end else if (host_drv_i) begin
      dq_wire_o = host_dat_i;
    end else begin
      dq_wire_o = ~last_ff; // a floating bus must not pass for held data
    end
  end
  assign clash_o = dq_oe_i & host_drv_i;
endmodule : fts_host_model

// ==== bench/testbench.sv ====
// Purpose: self-checking bench of the flow-through burst memory port
// Assumes: inputs change on the falling edge; outputs sampled 1 ns after the rising edge, the reset and output enable checks 1 ns after the falling one
// Notes:   host lets go of write data at its sampling edge; sleep is pulsed once at the end
`timescale 1ns/100ps
module testbench;
  import fts_pkg::*;
  localparam logic [17:0] D1 = 18'h2AB55;
  localparam logic [17:0] D2 = 18'h15AA3;
  localparam logic [17:0] EXP1 = {D1[17:9], D2[8:0]};
  logic        clk_i, rst_i, qual_n, mode, oe_n, host_drv, clash, oe, sleep;
  fts_cmd_type cmd;
  logic [17:0] dq_wire, dq_out, host_dat;
  int          fail_count, check_count;

  fts_sram_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .clock_qualifier_n_i(qual_n),
    .cmd_i(cmd), .mode_i(mode), .output_enable_n_i(oe_n), .sleep_request_i(sleep),
    .dq_i(dq_wire), .dq_o(dq_out), .dq_oe_o(oe));
  fts_host_model host_u (.clk_i(clk_i), .dq_o_i(dq_out), .dq_oe_i(oe),
    .host_drv_i(host_drv), .host_dat_i(host_dat), .dq_wire_o(dq_wire), .clash_o(clash));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic fts_cmd_type mk(logic [17:0] a, int adv, int wn, logic [1:0] bw,
                                     int desel);
    mk = '{addr: a, advance_or_load: (adv != 0), select_one_n: (desel == 1),
           select_two: (desel != 2), select_three_n: (desel == 3), write_n: (wn != 0),
           byte_lane_write_n: bw};
  endfunction : mk

  task automatic check(string what, logic [17:0] exp, logic [17:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one host cycle: command plus the data of the previous write, then settle
  task automatic step(fts_cmd_type c, int drv, logic [17:0] d);
    @(negedge clk_i);
    cmd = c;
    host_drv = (drv != 0);
    host_dat = d;
    @(posedge clk_i);
    host_drv <= 1'b0; // host lets go once its data edge has passed
    #1;
    check("bus clash", 18'h0, {17'h0, clash});
  endtask : step

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic s_lanes();
    step(mk(18'h00010, 0, 0, 2'h0, 0), 0, 18'h0);
    check("oe in write data", 18'h0, {17'h0, oe});
    step(mk(18'h00010, 0, 0, 2'h2, 0), 1, D1);
    check("oe in write data", 18'h0, {17'h0, oe});
    step(mk(18'h00010, 0, 1, 2'h3, 0), 1, D2);
    check("read word", EXP1, dq_out);
    check("oe on read", 18'h1, {17'h0, oe});
  endtask : s_lanes

  task automatic s_mask();
    @(negedge clk_i);
    qual_n = 1'b1;
    step(mk(18'h00010, 0, 0, 2'h0, 0), 1, 18'h3FFFF);
    step(mk(18'h00010, 0, 0, 2'h0, 0), 1, 18'h3FFFF);
    check("held word", EXP1, dq_out);
    check("held oe", 18'h1, {17'h0, oe});
    // the read must stand before the qualifier returns, or the masked write would land
    @(negedge clk_i);
    qual_n = 1'b0;
    cmd = mk(18'h00010, 0, 1, 2'h3, 0);
    host_drv = 1'b0;
    @(posedge clk_i);
    #1;
    check("word after masked write", EXP1, dq_out);
  endtask : s_mask

  task automatic s_desel();
    for (int k = 1; k <= 3; k++) begin
      step(mk(18'h00010, 0, 1, 2'h3, k), 0, 18'h0);
      check("oe deselected", 18'h0, {17'h0, oe});
      step(mk(18'h00010, 0, 1, 2'h3, 0), 0, 18'h0);
      check("oe first after deselect", 18'h0, {17'h0, oe});
      check("word after deselect", EXP1, dq_out);
      step(mk(18'h00010, 0, 1, 2'h3, 0), 0, 18'h0);
      check("oe selected", 18'h1, {17'h0, oe});
    end
  endtask : s_desel

  task automatic s_oe();
    @(negedge clk_i);
    oe_n = 1'b1;
    #1;
    check("oe gated", 18'h0, {17'h0, oe});
    @(negedge clk_i);
    oe_n = 1'b0;
    #1;
    check("oe ungated", 18'h1, {17'h0, oe});
  endtask : s_oe

  task automatic s_burst();
    logic [1:0] lo;
    step(mk(18'h00104, 0, 0, 2'h0, 0), 0, 18'h0);
    for (int k = 1; k <= 3; k++) begin
      step(mk(18'h00104 + 18'(k), 0, 0, 2'h0, 0), 1, 18'h01000 + 18'(k - 1));
    end
    step(mk(18'h00104, 0, 1, 2'h3, 0), 1, 18'h01003);
    check("word after writes", 18'h01000, dq_out);
    for (int m = 0; m <= 1; m++) begin
      for (int s = 1; s <= 3; s += 2) begin
        @(negedge clk_i);
        mode = m[0];
        step(mk(18'h00104 + 18'(s), 0, 1, 2'h3, 0), 0, 18'h0);
        check("burst start", 18'h01000 + 18'(s), dq_out);
        for (int k = 1; k <= 3; k++) begin
          lo = m[0] ? 2'(s ^ k) : 2'(s + k);
          step(mk(18'h3FFF0, 1, 1, 2'h3, 0), 0, 18'h0);
          check("burst beat", 18'h01000 + 18'(lo), dq_out);
        end
      end
    end
  endtask : s_burst

  task automatic s_sleep();
    @(negedge clk_i);
    sleep = 1'b1;
    @(posedge clk_i);
    #1;
    check("oe in sleep", 18'h0, {17'h0, oe});
    @(negedge clk_i);
    sleep = 1'b0;
    step(mk(18'h00010, 0, 1, 2'h3, 0), 0, 18'h0);
    check("oe first after sleep", 18'h0, {17'h0, oe});
    check("word after sleep", EXP1, dq_out);
  endtask : s_sleep

  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    $display("unexpected run length expected 2000 seen more");
    tally_and_finish();
  end

  initial begin
    rst_i = 1'b1;
    qual_n = 1'b0;
    mode = MODE_LINEAR;
    oe_n = 1'b0;
    host_drv = 1'b0;
    host_dat = 18'h0;
    sleep = 1'b0;
    cmd = mk(18'h0, 0, 1, 2'h3, 1);
    fail_count = 0;
    check_count = 0;
    // count rising edges: the time-zero start of the clock may look like a falling one
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    #1;
    check("oe after reset", 18'h0, {17'h0, oe});
    s_lanes();
    s_mask();
    s_desel();
    s_oe();
    s_burst();
    s_sleep();
    tally_and_finish();
  end
endmodule : testbench
